// >>> rtl/ocl_option_loader.sv
// ocl_option_loader: reset-time option fetch, trim access and flash timing registers.
// assumes: mclk is the oscillator clock that samples flash; flash data is valid the
// cycle after flashRead; Avalon-MM master follows waitrequest.
//
// Register access over Avalon-MM is this design's own decision.
`default_nettype none

// Functional notes
// - flash kHz value is high byte then low
// - option bytes change only during load
// - fetch options on reset and stop recovery
// - option registers unreachable from software bus
// - user option bytes from program addresses 0,1
// - erasing page zero erases user options
// - factory trim survives erase, working copy volatile
// - trim data write updates indexed working byte
// - trim data read returns indexed working byte
// - trim index plus 20h is information address
// - indices outside trim window unreachable
// - 43 reads, counter low bits, high zero
// - capture each fetched byte, 344 bits max
// - first two program bytes, rest information area
// - write protect zero blocks program and erase
module ocl_option_loader
    import ocl_pkg::*;
#(
    parameter int LOAD_BYTES = OCL_LOAD_COUNT,
    parameter int TRIM_BYTES = OCL_TRIM_COUNT
) (
    input  wire logic                      mclk,            // system clock, 25 MHz
    input  wire logic                      rst_n,           // synchronous reset, active low
    input  wire logic                      ce,              // clock enable, freezes all state
    input  wire logic                      stopRecover,     // stop-mode recovery pulse
    input  wire logic [OCL_BUS_ADDR_W-1:0] avs_address,     // byte address
    input  wire logic                      avs_read,        // read request
    input  wire logic                      avs_write,       // write request
    input  wire logic [31:0]               avs_writedata,   // write data
    output logic      [31:0]               avs_readdata,    // read data
    output logic                           avs_waitrequest, // stall
    output logic      [15:0]               flashAddr,       // flash address
    output logic                           flashInfoSel,    // information area select
    output logic                           flashRead,       // flash read strobe
    input  wire logic [7:0]                flashData,       // flash read data
    output logic      [8*LOAD_BYTES-1:0]   optionBits,      // hidden option registers
    output logic      [8*TRIM_BYTES-1:0]   trimWorking,     // working trim bytes
    output logic      [15:0]               flashKhzValue,   // program/erase timing value
    output logic                           progEraseBlocked,// write protect in force
    output logic                           cpuResetHold     // keeps the CPU in reset
);
    ocl_load_if ld ();
    ocl_trim_if tr ();

    logic [7:0]  trimIndex;
    logic [7:0]  khzHigh;
    logic [7:0]  khzLow;
    logic [7:0]  optRegs [LOAD_BYTES];
    logic [31:0] readMux;
    logic        busReq;
    logic        commit;
    logic [11:0] regIdx;

    // true where the index names a byte inside the trim window
    function automatic logic inTrimWindow(input logic [7:0] idx);
        return idx < 8'(TRIM_BYTES);
    endfunction

    ocl_load_seq #(
        .LOAD_BYTES(LOAD_BYTES)
    ) uSeq (
        .mclk        (mclk),
        .rst_n       (rst_n),
        .ce          (ce),
        .ld          (ld),
        .flashAddr   (flashAddr),
        .flashInfoSel(flashInfoSel),
        .flashRead   (flashRead)
    );

    ocl_trim_store #(
        .TRIM_BYTES(TRIM_BYTES)
    ) uTrim (
        .mclk (mclk),
        .rst_n(rst_n),
        .ce   (ce),
        .tr   (tr)
    );

    assign ld.restart = stopRecover;
    assign busReq     = avs_read | avs_write;
    assign regIdx     = avs_address[OCL_BUS_ADDR_W-1:2];
    assign commit     = busReq && !avs_waitrequest;

    // load-time capture into trim store: counter addresses 20h and up
    assign tr.ldWe   = ld.capValid && (ld.capIndex >= OCL_TRIM_BASE);
    assign tr.ldIdx  = 5'(ld.capIndex - OCL_TRIM_BASE);
    assign tr.ldData = flashData;
    // software write to trim data, only inside the window
    assign tr.swWe   = commit && avs_write && (regIdx == OCL_TRIM_VALUE_IDX)
                       && inTrimWindow(trimIndex);
    assign tr.swIdx  = trimIndex[4:0];
    assign tr.swData = avs_writedata[7:0];
    assign tr.rdIdx  = trimIndex[4:0];
    assign trimWorking = tr.working;

    // hidden option registers: only the fetch writes them, no bus path
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            for (int i = 0; i < LOAD_BYTES; i++) begin
                optRegs[i] <= 8'hFF;
            end
        end else if (ce) begin
            if (ld.capValid) begin
                optRegs[ld.capIndex] <= flashData;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < LOAD_BYTES; g++) begin : gOpt
            assign optionBits[8*g +: 8] = optRegs[g];
        end
    endgenerate

    // write protect taken from the freshly fetched byte 0; blocked until known
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            progEraseBlocked <= 1'b1;
        end else if (ce) begin
            if (ld.capValid && (ld.capIndex == 6'h00)) begin
                progEraseBlocked <= ~flashData[OCL_WP_BIT];
            end
        end
    end

    // CPU released only after the last byte lands
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cpuResetHold <= 1'b1;
        end else if (ce) begin
            cpuResetHold <= ld.loading || (stopRecover && !ld.loading);
        end
    end

    // timing value joined high over low
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            flashKhzValue <= {OCL_KHZ_HIGH_RST, OCL_KHZ_LOW_RST};
        end else if (ce) begin
            flashKhzValue <= {khzHigh, khzLow};
        end
    end

    // software registers; trim index untouched by data accesses
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            trimIndex <= OCL_TRIM_INDEX_RST;
            khzHigh   <= OCL_KHZ_HIGH_RST;
            khzLow    <= OCL_KHZ_LOW_RST;
        end else if (ce) begin
            if (commit && avs_write) begin
                case (regIdx)
                    OCL_TRIM_INDEX_IDX: trimIndex <= avs_writedata[7:0];
                    OCL_KHZ_HIGH_IDX:   khzHigh   <= avs_writedata[7:0];
                    OCL_KHZ_LOW_IDX:    khzLow    <= avs_writedata[7:0];
                    default:            trimIndex <= trimIndex;
                endcase
            end
        end
    end

    // read mux; unmapped and out-of-window reads return zero
    always_comb begin
        readMux = 32'h0000_0000;
        case (regIdx)
            OCL_TRIM_INDEX_IDX:  readMux[7:0] = trimIndex;
            OCL_TRIM_VALUE_IDX:  readMux[7:0] = inTrimWindow(trimIndex) ? tr.rdData : 8'h00;
            OCL_KHZ_HIGH_IDX:    readMux[7:0] = khzHigh;
            OCL_KHZ_LOW_IDX:     readMux[7:0] = khzLow;
            OCL_LOAD_STATUS_IDX: begin
                readMux[OCL_STAT_LOADING] = ld.loading;
                readMux[OCL_STAT_BLOCKED] = progEraseBlocked;
            end
            default:             readMux = 32'h0000_0000;
        endcase
    end

    // one wait cycle per access; held off entirely while the fetch runs,
    // which costs latency but keeps software away from half-loaded state
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else if (ce) begin
            if (!avs_waitrequest) begin
                avs_waitrequest <= 1'b1;
            end else if (busReq && !ld.loading) begin
                avs_waitrequest <= 1'b0;
                avs_readdata    <= avs_read ? readMux : 32'h0000_0000;
            end
        end
    end

    // checks
    khz_join_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && commit && avs_write && regIdx == OCL_KHZ_HIGH_IDX) ##1 ce |=>
        flashKhzValue[15:8] == $past(avs_writedata[7:0], 2))
        else $error("kHz high byte not in upper half");

    hold_while_load_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ld.loading |=> cpuResetHold)
        else $error("CPU released during option fetch");

    load_length_a: assert property (@(posedge mclk) disable iff (!rst_n || !ce)
        $rose(flashRead) |-> flashRead[*8] ##[35:40] !flashRead)
        else $error("fetch length wrong");

    restart_load_a: assert property (@(posedge mclk) disable iff (!rst_n || !ce)
        (stopRecover && !ld.loading) |-> ##[1:3] flashRead ##0 flashAddr[5:0] == 6'h00)
        else $error("stop recovery did not restart fetch");

    addr_shape_a: assert property (@(posedge mclk) disable iff (!rst_n)
        flashRead |-> (flashAddr[15:6] == 10'h000) && (flashInfoSel == (flashAddr[5:0] >= OCL_USER_BYTES)))
        else $error("fetch address or area wrong");

    options_stable_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !ld.loading |=> $stable(optionBits))
        else $error("options changed outside fetch");

    trim_write_a: assert property (@(posedge mclk) disable iff (!rst_n || !ce)
        (tr.swWe) |=> tr.rdData == $past(avs_writedata[7:0]))
        else $error("trim write lost");

    trim_window_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (commit && avs_read && regIdx == OCL_TRIM_VALUE_IDX && !inTrimWindow(trimIndex))
        |-> avs_readdata == 32'h0000_0000)
        else $error("trim access outside window");

    trim_map_a: assert property (@(posedge mclk) disable iff (!rst_n || !ce)
        tr.ldWe |=> tr.working[8*$past(tr.ldIdx) +: 8] == $past(flashData))
        else $error("trim byte landed at wrong index");

    wp_follow_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (!ld.loading && !cpuResetHold) |-> progEraseBlocked == ~optionBits[OCL_WP_BIT])
        else $error("write protect does not follow option");

    index_kept_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (commit && regIdx == OCL_TRIM_VALUE_IDX) |=> $stable(trimIndex))
        else $error("trim index moved on data access");
endmodule

`default_nettype wire

// >>> rtl/ocl_pkg.sv
// ocl_pkg: constants shared by the option configuration loader files.
// assumes: single system clock, Avalon-MM register access with byte addressing.
`default_nettype none

package ocl_pkg;
    // register indices; byte address is four times the index
    localparam logic [11:0] OCL_TRIM_INDEX_IDX  = 12'hFF6;
    localparam logic [11:0] OCL_TRIM_VALUE_IDX  = 12'hFF7;
    localparam logic [11:0] OCL_KHZ_HIGH_IDX    = 12'hFFA;
    localparam logic [11:0] OCL_KHZ_LOW_IDX     = 12'hFFB;
    localparam logic [11:0] OCL_LOAD_STATUS_IDX = 12'hFF0;
    localparam int          OCL_BUS_ADDR_W      = 14;

    // reset values
    localparam logic [7:0]  OCL_TRIM_INDEX_RST  = 8'h00;
    localparam logic [7:0]  OCL_KHZ_HIGH_RST    = 8'h00;
    localparam logic [7:0]  OCL_KHZ_LOW_RST     = 8'h00;
    localparam logic [7:0]  OCL_TRIM_WORK_RST   = 8'h00;

    // load sequence
    localparam int          OCL_LOAD_COUNT      = 43;
    localparam logic [5:0]  OCL_USER_BYTES      = 6'h02;
    localparam logic [5:0]  OCL_TRIM_BASE       = 6'h20;
    localparam int          OCL_TRIM_COUNT      = 32;
    localparam int          OCL_FLASH_ADDR_W    = 16;

    // field positions
    localparam int          OCL_WP_BIT          = 0;
    localparam int          OCL_STAT_LOADING    = 0;
    localparam int          OCL_STAT_BLOCKED    = 1;

    typedef enum logic [1:0] {
        OCL_SEQ_LOAD,
        OCL_SEQ_DRAIN,
        OCL_SEQ_DONE
    } ocl_seq_state_t;
endpackage

`default_nettype wire

// >>> rtl/ocl_ifs.sv
// ocl_ifs: carriers between the loader top and its sequencer and trim store.
// assumes: all signals are synchronous to the system clock.
`default_nettype none

interface ocl_load_if;
    logic       loading;    // load sequence running
    logic       capValid;   // flash byte on flashData this cycle
    logic [5:0] capIndex;   // counter address of that byte
    logic       restart;    // stop-mode recovery request
    modport seq  (output loading, output capValid, output capIndex, input restart);
    modport host (input loading, input capValid, input capIndex, output restart);
endinterface

interface ocl_trim_if;
    logic         ldWe;     // load-time write
    logic [4:0]   ldIdx;
    logic [7:0]   ldData;
    logic         swWe;     // software write
    logic [4:0]   swIdx;
    logic [7:0]   swData;
    logic [4:0]   rdIdx;
    logic [7:0]   rdData;
    logic [255:0] working;  // all working trim bytes
    modport store (input ldWe, input ldIdx, input ldData, input swWe, input swIdx, input swData,
                   input rdIdx, output rdData, output working);
    modport host  (output ldWe, output ldIdx, output ldData, output swWe, output swIdx, output swData,
                   output rdIdx, input rdData, input working);
endinterface

`default_nettype wire

// >>> rtl/ocl_load_seq.sv
// ocl_load_seq: counter that walks the flash through the option fetch.
// assumes: flash answers one cycle after the address and read strobe.
`default_nettype none

module ocl_load_seq
    import ocl_pkg::*;
#(
    parameter int LOAD_BYTES = OCL_LOAD_COUNT
) (
    input  wire logic        mclk,        // system clock
    input  wire logic        rst_n,       // synchronous reset, active low
    input  wire logic        ce,          // clock enable
    ocl_load_if.seq          ld,          // towards loader top
    output logic [15:0]      flashAddr,   // flash address
    output logic             flashInfoSel,// 1 selects information area
    output logic             flashRead    // read strobe
);
    ocl_seq_state_t state;
    logic [5:0]     count;
    logic           pendValid;
    logic [5:0]     pendIndex;

    // main counter; restart only once idle so a half load never mixes
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state <= OCL_SEQ_LOAD;
            count <= 6'h00;
        end else if (ce) begin
            case (state)
                OCL_SEQ_LOAD: begin
                    count <= count + 6'h01;
                    if (count == 6'(LOAD_BYTES - 1)) begin
                        state <= OCL_SEQ_DRAIN;
                    end
                end
                OCL_SEQ_DRAIN: state <= OCL_SEQ_DONE;
                OCL_SEQ_DONE: begin
                    if (ld.restart) begin
                        state <= OCL_SEQ_LOAD;
                        count <= 6'h00;
                    end
                end
                default: state <= OCL_SEQ_DONE;
            endcase
        end
    end

    // flash address: low six bits from the counter, rest held at zero
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            flashRead    <= 1'b0;
            flashAddr    <= 16'h0000;
            flashInfoSel <= 1'b0;
        end else if (ce) begin
            flashRead    <= (state == OCL_SEQ_LOAD);
            flashAddr    <= {10'h000, count};
            flashInfoSel <= (count >= OCL_USER_BYTES);
        end
    end

    // data returns a cycle after the strobe
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pendValid <= 1'b0;
            pendIndex <= 6'h00;
        end else if (ce) begin
            pendValid <= flashRead;
            pendIndex <= flashAddr[5:0];
        end
    end

    assign ld.capValid = pendValid;
    assign ld.capIndex = pendIndex;
    assign ld.loading  = (state != OCL_SEQ_DONE) || flashRead || pendValid;
endmodule

`default_nettype wire

// >>> rtl/ocl_trim_store.sv
// ocl_trim_store: working copy of the trim bytes, volatile by nature.
// assumes: load and software writes never coincide (bus is stalled during load).
`default_nettype none

module ocl_trim_store
    import ocl_pkg::*;
#(
    parameter int TRIM_BYTES = OCL_TRIM_COUNT
) (
    input  wire logic mclk,   // system clock
    input  wire logic rst_n,  // synchronous reset, active low
    input  wire logic ce,     // clock enable
    ocl_trim_if.store tr      // access ports
);
    logic [7:0] mem [TRIM_BYTES];

    // plain flops: working values vanish with power, flash copy untouched
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            for (int i = 0; i < TRIM_BYTES; i++) begin
                mem[i] <= OCL_TRIM_WORK_RST;
            end
        end else if (ce) begin
            if (tr.ldWe) begin
                mem[tr.ldIdx] <= tr.ldData;
            end else if (tr.swWe) begin
                mem[tr.swIdx] <= tr.swData;
            end
        end
    end

    assign tr.rdData = mem[tr.rdIdx];

    genvar g;
    generate
        for (g = 0; g < TRIM_BYTES; g++) begin : gFlat
            assign tr.working[8*g +: 8] = mem[g];
        end
    endgenerate
endmodule

`default_nettype wire

// >>> verification/ocl_flash_model.sv
// ocl_flash_model: behavioural flash seen by the option loader, program and info areas.
// assumes: one cycle read latency; bench sets the two user bytes through ports.
`default_nettype none

module ocl_flash_model (
    input  wire logic [15:0] flashAddr,    // read address
    input  wire logic        flashInfoSel, // 1 selects information area
    input  wire logic        flashRead,    // read strobe
    input  wire logic        mclk,         // system clock
    input  wire logic [7:0]  progByte0,    // program memory byte 0
    input  wire logic [7:0]  progByte1,    // program memory byte 1
    output logic      [7:0]  flashData     // read data
);
    timeunit 1ns;
    timeprecision 1ps;

    initial flashData = 8'h00;

    // data churns when not read, so a stale capture never matches by luck
    always @(posedge mclk) begin
        if (flashRead === 1'b1 && flashInfoSel === 1'b0) begin
            flashData <= flashAddr[0] ? progByte1 : progByte0;
        end else if (flashRead === 1'b1) begin
            flashData <= 8'h80 | {2'b00, flashAddr[5:0]};
        end else begin
            flashData <= ~flashData;
        end
    end
endmodule

`default_nettype wire

// >>> verification/ocl_option_loader_bench.sv
// ocl_option_loader_bench: self-checking bench for the option loader.
// assumes: Avalon-MM master with waitrequest; flash modelled by ocl_flash_model.
`default_nettype none

module ocl_option_loader_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import ocl_pkg::*;

    logic         mclk;
    logic         rst_n;
    logic         ce;
    logic         stopRecover;
    logic [13:0]  avs_address;
    logic         avs_read;
    logic         avs_write;
    logic [31:0]  avs_writedata;
    logic [31:0]  avs_readdata;
    logic         avs_waitrequest;
    logic [15:0]  flashAddr;
    logic         flashInfoSel;
    logic         flashRead;
    logic [7:0]   flashData;
    logic [343:0] optionBits;
    logic [255:0] trimWorking;
    logic [15:0]  flashKhzValue;
    logic         progEraseBlocked;
    logic         cpuResetHold;
    logic [7:0]   progByte0;
    logic [7:0]   progByte1;
    int           n_errors = 0;
    int           n_checks = 0;
    int           walkIdx = 0;
    int           lastWalk = 0;

    ocl_option_loader ocl_option_loader_i (
        .mclk(mclk), .rst_n(rst_n), .ce(ce), .stopRecover(stopRecover),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .flashAddr(flashAddr),
        .flashInfoSel(flashInfoSel), .flashRead(flashRead), .flashData(flashData),
        .optionBits(optionBits), .trimWorking(trimWorking), .flashKhzValue(flashKhzValue),
        .progEraseBlocked(progEraseBlocked), .cpuResetHold(cpuResetHold)
    );

    ocl_flash_model ocl_flash_model_i (
        .flashAddr(flashAddr), .flashInfoSel(flashInfoSel), .flashRead(flashRead),
        .mclk(mclk), .progByte0(progByte0), .progByte1(progByte1), .flashData(flashData)
    );

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // watches every fetch walk as it happens
    always @(posedge mclk) begin
        if (flashRead === 1'b1) begin
            chk(flashAddr, 32'(walkIdx));
            chk(flashInfoSel, walkIdx >= 2);
            chk(cpuResetHold, 1'b1);
            walkIdx++;
        end else if (walkIdx != 0) begin
            lastWalk = walkIdx;
            walkIdx = 0;
        end
    end

    // one bus access; held until waitrequest is sampled low
    task automatic xfer(input logic [11:0] idx, input logic wr, input logic [7:0] wd,
                        output logic [31:0] rdata);
        int n;
        n = 0;
        @(posedge mclk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h000000, wd};
        avs_write <= wr;
        avs_read <= ~wr;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0 && n < 200) begin
            n++;
            @(posedge mclk);
        end
        chk(n < 200, 1'b1);
        rdata = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] idx, input logic [7:0] d);
        logic [31:0] unused;
        xfer(idx, 1'b1, d, unused);
    endtask

    task automatic rd_chk(input logic [11:0] idx, input logic [7:0] exp);
        logic [31:0] got;
        xfer(idx, 1'b0, 8'h00, got);
        chk(got, {24'h000000, exp});
    endtask

    // stop-mode recovery pulse, then wait out the refetch
    task automatic recover();
        int n;
        n = 0;
        @(posedge mclk);
        stopRecover <= 1'b1;
        @(posedge mclk);
        stopRecover <= 1'b0;
        repeat (4) @(posedge mclk);
        chk(cpuResetHold, 1'b1);
        while (cpuResetHold !== 1'b0 && n < 100) begin
            n++;
            @(posedge mclk);
        end
        chk(n < 100, 1'b1);
        @(posedge mclk);
    endtask

    task automatic t_regs();
        rd_chk(OCL_TRIM_INDEX_IDX, 8'h00); // stalls across the load
        chk(cpuResetHold, 1'b0);
        rd_chk(OCL_KHZ_HIGH_IDX, 8'h00);
        rd_chk(OCL_KHZ_LOW_IDX, 8'h00);
        // 25 MHz in kHz; no program/erase is tried, clock is above 20 MHz
        wr(OCL_KHZ_HIGH_IDX, 8'h61);
        wr(OCL_KHZ_LOW_IDX, 8'hA8);
        rd_chk(OCL_KHZ_HIGH_IDX, 8'h61);
        rd_chk(OCL_KHZ_LOW_IDX, 8'hA8);
        chk(flashKhzValue, 16'h61A8);
        wr(12'hFF1, 8'h77);
        rd_chk(12'hFF1, 8'h00);
        rd_chk(12'h000, 8'h00);
        rd_chk(OCL_LOAD_STATUS_IDX, 8'h00);
        $display("test regs done");
    endtask

    task automatic t_load();
        logic [7:0] e;
        chk(lastWalk, 43);
        for (int k = 0; k < 43; k++) begin
            e = (k == 0) ? 8'h5B : (k == 1) ? 8'hC6 : (8'h80 | 8'(k));
            chk(optionBits[8*k+:8], e);
        end
        for (int i = 0; i < 32; i++) begin
            e = (i <= 10) ? (8'hA0 + 8'(i)) : 8'h00;
            chk(trimWorking[8*i+:8], e);
        end
        chk(progEraseBlocked, 1'b0);
        $display("test load done");
    endtask

    task automatic t_trim();
        wr(OCL_TRIM_INDEX_IDX, 8'h03);
        rd_chk(OCL_TRIM_VALUE_IDX, 8'hA3);
        wr(OCL_TRIM_VALUE_IDX, 8'h5C);
        rd_chk(OCL_TRIM_INDEX_IDX, 8'h03);
        rd_chk(OCL_TRIM_VALUE_IDX, 8'h5C);
        chk(trimWorking[31:24], 8'h5C);
        wr(OCL_TRIM_INDEX_IDX, 8'h1F);
        wr(OCL_TRIM_VALUE_IDX, 8'hE1);
        rd_chk(OCL_TRIM_VALUE_IDX, 8'hE1);
        chk(trimWorking[255:248], 8'hE1);
        // index 20h must not alias onto index 0
        wr(OCL_TRIM_INDEX_IDX, 8'h20);
        wr(OCL_TRIM_VALUE_IDX, 8'h99);
        rd_chk(OCL_TRIM_VALUE_IDX, 8'h00);
        chk(trimWorking[7:0], 8'hA0);
        $display("test trim done");
    endtask

    task automatic t_reload();
        @(posedge mclk);
        progByte0 <= 8'h5A;
        repeat (3) @(posedge mclk);
        chk(optionBits[7:0], 8'h5B);
        chk(progEraseBlocked, 1'b0);
        recover();
        chk(lastWalk, 43);
        chk(optionBits[7:0], 8'h5A);
        chk(progEraseBlocked, 1'b1);
        // page zero erased: both user bytes fall back to FF
        progByte0 <= 8'hFF;
        progByte1 <= 8'hFF;
        recover();
        chk(optionBits[15:0], 16'hFFFF);
        chk(optionBits[23:16], 8'h82);
        chk(progEraseBlocked, 1'b0);
        $display("test reload done");
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // hang guard, far beyond the few hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge mclk);
        n_errors++;
        close_out();
    end

    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        stopRecover = 1'b0;
        avs_address = 14'h0000;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h00000000;
        progByte0 = 8'h5B;
        progByte1 = 8'hC6;
        repeat (4) @(posedge mclk);
        chk(cpuResetHold, 1'b1);
        chk(avs_waitrequest, 1'b1);
        rst_n <= 1'b1;
        t_regs();
        t_load();
        t_trim();
        t_reload();
        close_out();
    end
endmodule

`default_nettype wire
